// ===== rtl/fpo_sequencer.sv
// Protection-override command sequencer with register port and interrupt requests.
// Assumes a single-cycle strobe register master and a stored key from the config field.
`timescale 1ns/1ps
`include "fpo_consts.svh"
module fpo_sequencer #(
	parameter int EXEC_CYC = `FPO_EXEC_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic [15:0] stored_key,
	input  wire logic        cmd_allowed,
	input  wire logic        single_fault_in,
	input  wire logic        stop_req,
	input  wire logic        wait_mode,
	output logic             stop_ack,
	output logic             cmd_irq,
	output logic             err_irq
);
	fpo_pkg::fpo_state_e state_q;
	logic [15:0]         words_q [4];
	logic [2:0]          parameter_index_q;
	fpo_pkg::fpo_prot_t  pflash_protection_reg_q;
	fpo_pkg::fpo_prot_t  eeprom_protection_reg_q;
	fpo_pkg::fpo_prot_t  save_pflash_q;
	fpo_pkg::fpo_prot_t  save_eeprom_q;
	logic                override_active_q;
	logic                command_complete_flag_q;
	logic                access_error_q;
	logic                protection_violation_q;
	logic                command_complete_irq_en_q;
	logic                single_fault_flag_q;
	logic                single_fault_irq_en_q;
	logic [7:0]          exec_cnt_q;
	logic                fault_sync;

	logic       wr_status;
	logic       launch;
	logic [1:0] sel;
	logic [15:0] key;
	logic       key_invalid;
	logic       feature_off;
	logic       key_match;
	logic       idx_ok;
	logic       want_restore;
	logic       launch_err;
	logic       exec_end;

	// Fault input arrives from the read path in another timing domain
	fpo_sync u_fault_sync (
		.core_clk (core_clk),
		.nrst     (nrst),
		.d        (single_fault_in),
		.q        (fault_sync)
	);

	// Launch: writing one to the complete flag while it is set starts a command
	assign wr_status    = reg_wr && (reg_addr == `FPO_ADDR_STATUS);
	assign launch       = wr_status && reg_wdata[`FPO_STAT_CCF_BIT] && command_complete_flag_q;
	assign sel          = words_q[0][1:0];
	assign key          = words_q[1];
	assign key_invalid  = (key == `FPO_ERASED_KEY);
	assign feature_off  = (stored_key == `FPO_ERASED_KEY);
	assign key_match    = !key_invalid && !feature_off && (key == stored_key);
	assign want_restore = !key_match;
	assign idx_ok       = (parameter_index_q == `FPO_IDX_ONE) ||
	                      (parameter_index_q == `FPO_IDX_TWO) ||
	                      (parameter_index_q == `FPO_IDX_THREE);

	// Launch error checks, evaluated against the loaded parameter words
	always_comb begin
		launch_err = 1'b0;
		if (words_q[0][15:8] != `FPO_CMD_OVERRIDE) begin
			launch_err = 1'b1; // Other commands are not served by this block
		end
		if (!idx_ok) begin
			launch_err = 1'b1;
		end
		if (!cmd_allowed) begin
			launch_err = 1'b1;
		end
		if (want_restore && !override_active_q) begin
			launch_err = 1'b1;
		end
		if ((sel == 2'b00) && ((parameter_index_q == `FPO_IDX_TWO) ||
		                       (parameter_index_q == `FPO_IDX_THREE))) begin
			launch_err = 1'b1;
		end
		if ((sel == 2'b00) && (parameter_index_q == `FPO_IDX_ONE) && !key_invalid) begin
			launch_err = 1'b1;
		end
	end

	assign exec_end = (state_q == fpo_pkg::FPO_EXEC) && (exec_cnt_q == 8'h00);

	// Command sequencer; wait mode is deliberately not an input to it
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_q    <= fpo_pkg::FPO_IDLE;
			exec_cnt_q <= 8'h00;
		end else begin
			case (state_q)
				fpo_pkg::FPO_IDLE: begin
					if (launch && !launch_err) begin
						state_q    <= fpo_pkg::FPO_EXEC;
						exec_cnt_q <= 8'(EXEC_CYC - 1);
					end
				end
				fpo_pkg::FPO_EXEC: begin
					if (exec_cnt_q == 8'h00) begin
						state_q <= fpo_pkg::FPO_DONE;
					end else begin
						exec_cnt_q <= exec_cnt_q - 8'h01;
					end
				end
				fpo_pkg::FPO_DONE: begin
					state_q <= fpo_pkg::FPO_IDLE;
				end
				default: begin
					state_q <= fpo_pkg::FPO_IDLE;
				end
			endcase
		end
	end

	// Complete flag: cleared by a launch without error, set again when execution ends
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			command_complete_flag_q <= 1'b1;
		end else if (launch && !launch_err) begin
			command_complete_flag_q <= 1'b0;
		end else if (exec_end) begin
			command_complete_flag_q <= 1'b1;
		end
	end

	// Error flags: access error set on a faulty launch, both cleared by writing one; set wins
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			access_error_q         <= 1'b0;
			protection_violation_q <= 1'b0;
		end else begin
			if (launch && launch_err) begin
				access_error_q <= 1'b1;
			end else if (wr_status && reg_wdata[`FPO_STAT_AERR_BIT]) begin
				access_error_q <= 1'b0;
			end
			if (wr_status && reg_wdata[`FPO_STAT_PVIOL_BIT]) begin
				protection_violation_q <= 1'b0; // This command never flags a violation
			end
		end
	end

	// Single fault flag is sticky; a new fault beats a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			single_fault_flag_q <= 1'b0;
		end else if (fault_sync) begin
			single_fault_flag_q <= 1'b1;
		end else if (reg_wr && (reg_addr == `FPO_ADDR_ERR_STATUS) && reg_wdata[0]) begin
			single_fault_flag_q <= 1'b0;
		end
	end

	// Configuration and parameter words; words are locked while a command runs
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			command_complete_irq_en_q <= 1'b0;
			single_fault_irq_en_q     <= 1'b0;
			parameter_index_q         <= 3'h0;
			for (int i = 0; i < 4; i++) begin
				words_q[i] <= 16'h0000;
			end
		end else if (reg_wr) begin
			if (reg_addr == `FPO_ADDR_CONFIG) begin
				command_complete_irq_en_q <= reg_wdata[7];
			end
			if (reg_addr == `FPO_ADDR_ERR_CONFIG) begin
				single_fault_irq_en_q <= reg_wdata[0];
			end
			if (command_complete_flag_q) begin
				if (reg_addr == `FPO_ADDR_INDEX) begin
					parameter_index_q <= reg_wdata[2:0];
				end
				for (int i = 0; i < 4; i++) begin
					if (reg_addr == (`FPO_ADDR_WORD0 + 8'(4 * i))) begin
						words_q[i] <= reg_wdata[15:0];
					end
				end
			end
		end
	end

	// Protection registers, save entry and override status
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pflash_protection_reg_q <= `FPO_PFLASH_PROT_RST;
			eeprom_protection_reg_q <= `FPO_EEPROM_PROT_RST;
			save_pflash_q           <= `FPO_PFLASH_PROT_RST;
			save_eeprom_q           <= `FPO_EEPROM_PROT_RST;
			override_active_q       <= 1'b0;
		end else if (launch && !launch_err) begin
			if (key_match) begin
				save_pflash_q <= pflash_protection_reg_q;
				save_eeprom_q <= eeprom_protection_reg_q;
				if (sel[`FPO_SEL_PFLASH_BIT]) begin
					pflash_protection_reg_q <= words_q[2][7:0];
				end
				if (sel[`FPO_SEL_EEPROM_BIT]) begin
					eeprom_protection_reg_q <= words_q[3][7:0];
				end
				override_active_q <= 1'b1;
			end else begin
				pflash_protection_reg_q <= save_pflash_q;
				eeprom_protection_reg_q <= save_eeprom_q;
				override_active_q       <= 1'b0;
			end
		end else if (reg_wr && command_complete_flag_q) begin
			// Direct writes are allowed, but those made while an override is active are lost by a later restore
			if (reg_addr == `FPO_ADDR_PFLASH_PROT) begin
				pflash_protection_reg_q <= reg_wdata[7:0];
			end
			if (reg_addr == `FPO_ADDR_EEPROM_PROT) begin
				eeprom_protection_reg_q <= reg_wdata[7:0];
			end
		end
	end

	// Read data one cycle after the strobe; unmapped addresses read zero
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`FPO_ADDR_STATUS:      reg_rdata <= {24'h0, command_complete_flag_q, 1'b0,
				                                     access_error_q, protection_violation_q,
				                                     4'h0};
				`FPO_ADDR_CONFIG:      reg_rdata <= {24'h0, command_complete_irq_en_q, 7'h0};
				`FPO_ADDR_ERR_STATUS:  reg_rdata <= {31'h0, single_fault_flag_q};
				`FPO_ADDR_ERR_CONFIG:  reg_rdata <= {31'h0, single_fault_irq_en_q};
				`FPO_ADDR_INDEX:       reg_rdata <= {29'h0, parameter_index_q};
				`FPO_ADDR_WORD0:       reg_rdata <= {16'h0, words_q[0]};
				`FPO_ADDR_WORD1:       reg_rdata <= {16'h0, words_q[1]};
				`FPO_ADDR_WORD2:       reg_rdata <= {16'h0, words_q[2]};
				`FPO_ADDR_WORD3:       reg_rdata <= {16'h0, words_q[3]};
				`FPO_ADDR_PFLASH_PROT: reg_rdata <= {24'h0, pflash_protection_reg_q};
				`FPO_ADDR_EEPROM_PROT: reg_rdata <= {24'h0, eeprom_protection_reg_q};
				`FPO_ADDR_PROT_STATUS: reg_rdata <= {31'h0, override_active_q};
				default:               reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// Level interrupt requests; the complete request also serves as wake from wait
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cmd_irq <= 1'b0;
			err_irq <= 1'b0;
		end else begin
			cmd_irq <= command_complete_flag_q && command_complete_irq_en_q;
			err_irq <= single_fault_flag_q && single_fault_irq_en_q;
		end
	end

	// Stop is granted only once no command is running
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			stop_ack <= 1'b0;
		end else begin
			stop_ack <= stop_req && command_complete_flag_q && !(launch && !launch_err);
		end
	end

	// Wait mode is observed but has no effect on the sequencer
	logic wait_seen;
	assign wait_seen = wait_mode;
endmodule

// ===== common/fpo_consts.svh
// Constants of the protection-override sequencer: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef FPO_CONSTS_SVH
`define FPO_CONSTS_SVH

`define FPO_CMD_OVERRIDE      8'h13
`define FPO_ERASED_KEY        16'hFFFF
`define FPO_SEL_PFLASH_BIT    0
`define FPO_SEL_EEPROM_BIT    1
`define FPO_IDX_ONE           3'h1
`define FPO_IDX_TWO           3'h2
`define FPO_IDX_THREE         3'h3
// Register offsets (word index = byte address / 4)
`define FPO_ADDR_STATUS       8'h00
`define FPO_ADDR_CONFIG       8'h04
`define FPO_ADDR_ERR_STATUS   8'h08
`define FPO_ADDR_ERR_CONFIG   8'h0C
`define FPO_ADDR_INDEX        8'h10
`define FPO_ADDR_WORD0        8'h14
`define FPO_ADDR_WORD1        8'h18
`define FPO_ADDR_WORD2        8'h1C
`define FPO_ADDR_WORD3        8'h20
`define FPO_ADDR_PFLASH_PROT  8'h24
`define FPO_ADDR_EEPROM_PROT  8'h28
`define FPO_ADDR_PROT_STATUS  8'h2C
// Status register fields
`define FPO_STAT_CCF_BIT      7
`define FPO_STAT_AERR_BIT     5
`define FPO_STAT_PVIOL_BIT    4
// Reset values
`define FPO_PFLASH_PROT_RST   8'hFF
`define FPO_EEPROM_PROT_RST   8'hFF
// Command execution time
`define FPO_EXEC_NS           40
`define FPO_CLK_NS            4
`define FPO_EXEC_CYC          ((`FPO_EXEC_NS + `FPO_CLK_NS - 1) / `FPO_CLK_NS)

`endif

// ===== common/fpo_pkg.sv
// Types of the protection-override sequencer.
// Assumes fpo_consts.svh on the include path.
`include "fpo_consts.svh"
package fpo_pkg;
	typedef enum logic [1:0] {
		FPO_IDLE,
		FPO_EXEC,
		FPO_DONE
	} fpo_state_e;
	typedef logic [7:0] fpo_prot_t;
endpackage

// ===== rtl/fpo_sync.sv
// Three-stage input synchroniser with agreement of the last two stages.
// Assumes an asynchronous level input and a synchronous active-low reset.
`timescale 1ns/1ps
`include "fpo_consts.svh"
module fpo_sync (
	input  wire logic core_clk,
	input  wire logic nrst,
	input  wire logic d,
	output logic      q
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// First stage feeds only the second; output moves when stages two and three agree
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			q    <= 1'b0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				q <= s3_q;
			end
		end
	end
endmodule

// ===== test/fpo_seq_monitor.sv
// Port-level assertions for the protection-override sequencer.
// Assumes a bind onto fpo_sequencer; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module fpo_seq_monitor #(
	parameter int EXEC_CYC = 10
) (
	input wire logic        core_clk,
	input wire logic        nrst,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [15:0] stored_key,
	input wire logic        cmd_allowed,
	input wire logic        single_fault_in,
	input wire logic        stop_req,
	input wire logic        wait_mode,
	input wire logic        stop_ack,
	input wire logic        cmd_irq,
	input wire logic        err_irq
);
	logic launch;
	// A launch is a write of one to the complete flag
	assign launch = reg_wr && reg_addr == 8'h00 && reg_wdata[7];
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// Busy command holds off stop entry; a refused launch may leave stop granted,
	// so only a launch that withheld stop is followed further
	launch_stop_a: assert property (launch && stop_req ##1 !stop_ack |=> !stop_ack)
		else $error("stop granted during command");
	stop_cause_a: assert property (stop_ack |-> $past(stop_req))
		else $error("stop granted without request");
	stop_done_a: assert property (cmd_irq && $past(stop_req) && !$past(launch) |-> stop_ack)
		else $error("stop withheld while idle");
	// Complete flag drops while a command runs
	launch_irq_a: assert property (launch |=> ##1 !cmd_irq)
		else $error("command interrupt during command");
	// Levels fall only after a register write
	cmd_hold_a: assert property (cmd_irq && !$past(reg_wr) |=> cmd_irq)
		else $error("command interrupt dropped");
	err_hold_a: assert property (err_irq && !$past(reg_wr) |=> err_irq)
		else $error("error interrupt dropped");
	irq_quiet_a: assert property (disable iff (1'b0) !nrst |=> !cmd_irq && !err_irq)
		else $error("interrupt during reset");
	stat_bits_a: assert property (reg_rd && reg_addr == 8'h2C |=> reg_rdata[31:1] == 31'h0)
		else $error("stray protection status bits");
	cover property (launch);
	cover property ($rose(cmd_irq));
	cover property ($rose(err_irq));
	cover property (stop_ack && cmd_irq);
endmodule

// ===== test/flash_protection_override_irq_bench.sv
// Self-checking bench for the protection-override sequencer.
// Assumes fpo_consts.svh on the include path and the monitor compiled first.
`timescale 1ns/1ps
`include "fpo_consts.svh"
module flash_protection_override_irq_bench;
	logic        clk, nrst, wr, rd_s, ok, sf, stp, wt, stop_ack, cmd_irq, err_irq;
	logic [7:0]  addr;
	logic [15:0] skey;
	logic [31:0] wd, rdv, rdata;
	int          n_fail, cmp_count, seed, pf, ee, sv_pf, sv_ee, act, err, i;
	logic [2:0]  it [7] = '{3'h3, 3'h0, 3'h4, 3'h3, 3'h2, 3'h3, 3'h1};
	logic [1:0]  st [7] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0};
	// Short execution count keeps the run brief
	fpo_sequencer #(.EXEC_CYC(2)) dut_u (.core_clk(clk), .nrst(nrst), .reg_addr(addr),
		.reg_wdata(wd), .reg_wr(wr), .reg_rd(rd_s), .reg_rdata(rdata), .stored_key(skey),
		.cmd_allowed(ok), .single_fault_in(sf), .stop_req(stp), .wait_mode(wt),
		.stop_ack(stop_ack), .cmd_irq(cmd_irq), .err_irq(err_irq));
	task automatic give_verdict();
		if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	// Bus cycles: one strobe cycle, then an idle cycle
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic r(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		r(a, rdv);
		chk(nm, e, rdv);
	endtask
	// Compare protections, override bit and status, then clear the error flag
	task automatic chk_state();
		rc("pflash", 8'h24, 32'(pf));
		rc("eeprom", 8'h28, 32'(ee));
		rc("active", 8'h2C, 32'(act));
		rc("status", 8'h00, {24'h0, 1'b1, 1'b0, err[0], 5'h0});
		w(8'h00, 32'h00000020);
		err = 0;
	endtask
	// Model the command, then launch it and poll for completion
	task automatic cmd(input logic [7:0] op, input logic [1:0] sel, input logic [15:0] key,
		input logic [2:0] idx, input logic al);
		logic [7:0] a, b;
		int m, k;
		@(posedge clk);
		ok <= al;
		wt <= 1'($random(seed)); // Wait mode must not matter
		a = 8'($random(seed));
		b = 8'($random(seed));
		m = key != 16'hFFFF && skey != 16'hFFFF && key == skey;
		err = op != 8'h13 || idx < 1 || idx > 3 || !al || (m == 0 && act == 0)
			|| (sel == 2'h0 && (idx != 1 || key != 16'hFFFF));
		if (err == 0 && m != 0) begin
			sv_pf = pf;
			sv_ee = ee;
			if (sel[0]) pf = a;
			if (sel[1]) ee = b;
			act = 1;
		end else if (err == 0) begin
			pf = sv_pf;
			ee = sv_ee;
			act = 0;
		end
		w(8'h10, {29'h0, idx});
		w(8'h14, {16'h0, op, 6'h0, sel});
		w(8'h18, {16'h0, key});
		w(8'h1C, {24'h0, a});
		w(8'h20, {24'h0, b});
		w(8'h00, 32'h00000080);
		rdv = 32'h0;
		for (k = 0; k < 20 && !rdv[7]; k++) begin
			r(8'h00, rdv);
			// While the command runs, stop must stay withheld
			if (!rdv[7]) chk("stop_busy", 32'h0, {31'h0, stop_ack});
		end
		if (rdv[7] !== 1'b1) begin
			n_fail++;
			give_verdict();
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		{nrst, wr, rd_s, sf, stp} = 5'h0;
		ok = 1'b1;
		wt = 1'b1;
		addr = 8'h0;
		wd = 32'h0;
		seed = 32'haa69;
		skey = {1'b0, 15'($random(seed))};
		{n_fail, cmp_count, act, err} = '0;
		{pf, ee, sv_pf, sv_ee} = {4{32'hFF}};
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		chk_state();
		rc("unmapped", 8'h40, 32'h0);
		cmd(8'h13, 2'h3, 16'hFFFF, 3'h1, 1'b1);
		chk_state();
		cmd(8'h13, 2'h1, skey, 3'h3, 1'b1);
		chk_state();
		cmd(8'h13, 2'h2, skey, 3'h3, 1'b1);
		chk_state();
		w(8'h24, 32'h00000012);
		pf = 8'h12;
		cmd(8'h13, 2'h3, skey ^ 16'h0001, 3'h3, 1'b1);
		chk_state();
		cmd(8'h13, 2'h3, skey, 3'h3, 1'b1);
		chk_state();
		for (i = 0; i < 7; i++) begin
			cmd(i == 0 ? 8'h12 : 8'h13, st[i], skey, it[i], i != 3);
			chk_state();
		end
		cmd(8'h13, 2'h3, 16'hFFFF, 3'h3, 1'b1);
		chk_state();
		// Stop is requested across an accepted command, with its interrupt enabled
		w(8'h04, 32'h00000080);
		repeat (2) @(posedge clk);
		#1 chk("cmd_irq", 32'h1, {31'h0, cmd_irq});
		@(posedge clk);
		stp <= 1'b1;
		cmd(8'h13, 2'h3, skey, 3'h3, 1'b1);
		chk("stop_ack", 32'h1, {31'h0, stop_ack});
		chk_state();
		// An erased stored key only ever restores the saved values
		@(posedge clk);
		skey <= 16'hFFFF;
		cmd(8'h13, 2'h3, 16'hFFFF, 3'h3, 1'b1);
		chk_state();
		w(8'h04, 32'h0);
		repeat (2) @(posedge clk);
		#1 chk("cmd_irq", 32'h0, {31'h0, cmd_irq});
		w(8'h0C, 32'h00000001);
		sf <= 1'b1;
		repeat (4) @(posedge clk);
		sf <= 1'b0;
		for (i = 0; i < 12 && err_irq !== 1'b1; i++) @(posedge clk);
		#1 chk("err_irq", 32'h1, {31'h0, err_irq});
		rc("fault", 8'h08, 32'h00000001);
		w(8'h08, 32'h00000001);
		repeat (2) @(posedge clk);
		#1 chk("err_irq", 32'h0, {31'h0, err_irq});
		give_verdict();
	end
endmodule
bind fpo_sequencer fpo_seq_monitor #(.EXEC_CYC(EXEC_CYC)) mon_u (.core_clk(core_clk),
	.nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .stored_key(stored_key),
	.cmd_allowed(cmd_allowed), .single_fault_in(single_fault_in), .stop_req(stop_req),
	.wait_mode(wait_mode), .stop_ack(stop_ack), .cmd_irq(cmd_irq), .err_irq(err_irq));
